// File: hw/mlw_arith.sv
// Purpose: combinational multiply, 33-bit accumulate and clamp of the low-halfword mac
// Assumes: operands are stable while the sequencer executes
// Notes: bit 0 is the least significant bit, so the low halfword is [15:0]
`timescale 1ns/1ns
`default_nettype none
`include "mlw_consts.svh"

module mlw_arith (
  input wire mlw_pkg::mlw_fam_e fam_i, // arithmetic family
  input wire logic [31:0] src_a_i, // first_source_reg
  input wire logic [31:0] src_b_i, // second_source_reg
  input wire logic [31:0] dest_i, // current destination
  output logic [31:0] prod_o, // 32-bit product
  output logic [32:0] sum_o, // 33-bit intermediate sum
  output logic ovf_o, // sum does not fit 32 bits
  output logic [31:0] result_o // value to write back
);
  import mlw_pkg::*;

  logic sgn;
  logic [31:0] prod_s;
  logic [31:0] prod_u;
  logic [31:0] clamp;

  // low halfword products in both signednesses
  assign sgn = mlw_is_signed(fam_i);
  assign prod_s = $signed(src_a_i[15:0]) * $signed(src_b_i[15:0]);
  assign prod_u = src_a_i[15:0] * src_b_i[15:0];
  assign prod_o = sgn ? prod_s : prod_u;

  // 33-bit accumulate, extended by signedness
  always_comb begin
    if (sgn) begin
      sum_o = {prod_o[31], prod_o} + {dest_i[31], dest_i};
      ovf_o = sum_o[32] ^ sum_o[31];
      clamp = sum_o[32] ? `MLW_SAT_SMIN : `MLW_SAT_SMAX;
    end else begin
      sum_o = {1'b0, prod_o} + {1'b0, dest_i};
      ovf_o = sum_o[32];
      clamp = `MLW_SAT_UMAX;
    end
  end

  // modulo keeps the low word, saturating clamps on overflow
  assign result_o = (mlw_is_sat(fam_i) && ovf_o) ? clamp : sum_o[31:0];

endmodule : mlw_arith
`default_nettype wire

// File: hw/mlw_top.sv
// Purpose: apb-controlled execution datapath for the low-halfword to word mac family
// Assumes: zero-wait apb slave, one clock, synchronous active-low reset
// Notes: a control write with go set runs one operation in the following cycle
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mlw_consts.svh"

module mlw_top (
  input wire logic clk_sys_i, // 250 MHz core clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction, high writes
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready, always high
  output logic pslverr_o, // apb error on unmapped address
  output logic irq_o // level interrupt
);
  import mlw_pkg::*;

  mlw_st_s st_r;
  mlw_st_s st_nxt;
  logic [31:0] prod;
  logic [32:0] sum;
  logic ovf;
  logic [31:0] result;
  logic wr_acc;
  logic rd_setup;
  logic exec;

  // address map, used for the error answer and the error checks
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `MLW_OFF_CTRL, `MLW_OFF_SRC_A, `MLW_OFF_SRC_B, `MLW_OFF_DEST, `MLW_OFF_FXEXC,
      `MLW_OFF_COND, `MLW_OFF_IRQ_STAT, `MLW_OFF_IRQ_EN, `MLW_OFF_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // arithmetic on the latched operands
  mlw_arith u_mlw_arith (
    .fam_i(st_r.fam),
    .src_a_i(st_r.src_a),
    .src_b_i(st_r.src_b),
    .dest_i(st_r.dest),
    .prod_o(prod),
    .sum_o(sum),
    .ovf_o(ovf),
    .result_o(result)
  );

  // bus phase decode
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i;
  assign exec = (st_r.state == MLW_ST_EXEC);

  // next-state logic for bus, sequencer, flags and interrupts
  always_comb begin
    logic [1:0] ev;
    logic [1:0] clr;
    logic so_new;
    ev = 2'h0;
    clr = 2'h0;
    so_new = st_r.so;
    st_nxt = st_r;
    st_nxt.pready = 1'b1;

    // register writes at the access edge
    if (wr_acc) begin
      case (paddr_i)
        `MLW_OFF_CTRL: begin
          st_nxt.fam = mlw_fam_e'(pwdata_i[`MLW_CTRL_FAM_HI:`MLW_CTRL_FAM_LO]);
          st_nxt.rec = pwdata_i[`MLW_CTRL_REC];
          st_nxt.oe = pwdata_i[`MLW_CTRL_OE];
          if (pwdata_i[`MLW_CTRL_GO]) begin
            st_nxt.state = MLW_ST_EXEC;
          end
        end
        `MLW_OFF_SRC_A: st_nxt.src_a = pwdata_i;
        `MLW_OFF_SRC_B: st_nxt.src_b = pwdata_i;
        `MLW_OFF_DEST: st_nxt.dest = pwdata_i;
        `MLW_OFF_FXEXC: begin
          st_nxt.ovf_flag = pwdata_i[`MLW_FXEXC_OVF];
          st_nxt.so = pwdata_i[`MLW_FXEXC_SO];
        end
        `MLW_OFF_IRQ_EN: st_nxt.irq_en = pwdata_i[1:0];
        `MLW_OFF_IRQ_CLR: clr = pwdata_i[1:0];
        default: begin
        end
      endcase
    end

    // sequencer: one execute cycle, then idle again
    case (st_r.state)
      MLW_ST_IDLE: begin
      end
      MLW_ST_EXEC: begin
        st_nxt.state = MLW_ST_IDLE;
        st_nxt.dest = result;
        ev[`MLW_IRQ_DONE] = 1'b1;
        ev[`MLW_IRQ_OVF] = ovf;
        // overflow-enabled forms refresh the overflow flag and accumulate so
        if (st_r.oe) begin
          st_nxt.ovf_flag = ovf;
          so_new = st_r.so | ovf;
          st_nxt.so = so_new;
        end
        // record forms compare the written value against zero
        if (st_r.rec) begin
          st_nxt.cond[`MLW_COND_LT] = result[31];
          st_nxt.cond[`MLW_COND_GT] = !result[31] && (result != 32'h0000_0000);
          st_nxt.cond[`MLW_COND_EQ] = (result == 32'h0000_0000);
          st_nxt.cond[`MLW_COND_SO] = so_new;
        end
      end
      default: st_nxt.state = MLW_ST_IDLE;
    endcase

    // sticky status: a new event wins over a clear in the same cycle
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);

    // read data and error are prepared in the setup cycle
    if (rd_setup) begin
      st_nxt.pslverr = !mapped(paddr_i);
      case (paddr_i)
        `MLW_OFF_CTRL: st_nxt.prdata = {26'h0, exec, 1'b0, st_r.oe, st_r.rec, st_r.fam};
        `MLW_OFF_SRC_A: st_nxt.prdata = st_r.src_a;
        `MLW_OFF_SRC_B: st_nxt.prdata = st_r.src_b;
        `MLW_OFF_DEST: st_nxt.prdata = st_r.dest;
        `MLW_OFF_FXEXC: st_nxt.prdata = {30'h0, st_r.so, st_r.ovf_flag};
        `MLW_OFF_COND: st_nxt.prdata = {28'h0, st_r.cond};
        `MLW_OFF_IRQ_STAT: st_nxt.prdata = {30'h0, st_r.irq_stat};
        `MLW_OFF_IRQ_EN: st_nxt.prdata = {30'h0, st_r.irq_en};
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end else if (!psel_i) begin
      st_nxt.pslverr = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r.state <= MLW_ST_IDLE;
      st_r.fam <= MLW_FAM_MOD_S;
      st_r.rec <= 1'b0;
      st_r.oe <= 1'b0;
      st_r.src_a <= `MLW_RST_WORD;
      st_r.src_b <= `MLW_RST_WORD;
      st_r.dest <= `MLW_RST_WORD;
      st_r.ovf_flag <= 1'b0;
      st_r.so <= 1'b0;
      st_r.cond <= `MLW_RST_COND;
      st_r.irq_stat <= `MLW_RST_IRQ;
      st_r.irq_en <= `MLW_RST_IRQ;
      st_r.prdata <= `MLW_RST_WORD;
      st_r.pslverr <= 1'b0;
      st_r.pready <= 1'b1;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign irq_o = st_r.irq;

  // checks on the datapath and the flag updates
  a_low_product: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && mlw_is_signed(st_r.fam) |-> $signed(prod) == $signed(st_r.src_a[15:0]) * $signed(st_r.src_b[15:0]))
    else $error("signed product not from low halfwords");

  a_unsigned_product: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && !mlw_is_signed(st_r.fam) |-> prod == {16'h0, st_r.src_a[15:0]} * {16'h0, st_r.src_b[15:0]})
    else $error("unsigned product wrong");

  a_sum_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && !mlw_is_signed(st_r.fam) |-> sum == {1'b0, st_r.dest} + {1'b0, prod})
    else $error("unsigned intermediate sum wrong");

  a_modulo_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && (!mlw_is_sat(st_r.fam) || !ovf) |=> st_r.dest == $past(sum[31:0]))
    else $error("destination not the low sum word");

  a_sat_clamp: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && mlw_is_sat(st_r.fam) && ovf |=> st_r.dest == ($past(mlw_is_signed(st_r.fam))
      ? ($past(sum[32]) ? `MLW_SAT_SMIN : `MLW_SAT_SMAX) : `MLW_SAT_UMAX))
    else $error("saturated destination not clamped");

  a_signed_bounds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && (st_r.fam == MLW_FAM_SAT_S) && ovf && !sum[32] |=> st_r.dest == 32'h7FFF_FFFF)
    else $error("positive overflow not clamped to max");

  a_base_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && !st_r.rec && !st_r.oe |=> $stable(st_r.cond) && $stable(st_r.ovf_flag) && $stable(st_r.so))
    else $error("base form changed flags");

  a_record_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && st_r.rec && !st_r.oe |=> $stable(st_r.ovf_flag) && $stable(st_r.so)
      && st_r.cond[`MLW_COND_EQ] == (st_r.dest == 32'h0000_0000) && st_r.cond[`MLW_COND_LT] == st_r.dest[31])
    else $error("record form flags wrong");

  a_oe_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && st_r.oe && !st_r.rec |=> $stable(st_r.cond) && st_r.ovf_flag == $past(ovf))
    else $error("overflow-enabled form flags wrong");

  a_oe_record: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && st_r.oe && st_r.rec |=> st_r.ovf_flag == $past(ovf) && st_r.cond[`MLW_COND_SO] == st_r.so
      && st_r.cond[`MLW_COND_GT] == (!st_r.dest[31] && st_r.dest != 32'h0000_0000))
    else $error("combined form flags wrong");

  a_so_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && st_r.oe && (ovf || st_r.so) |=> st_r.so ##1 (st_r.so || $past(wr_acc)))
    else $error("summary overflow not sticky");

  a_go_runs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_acc && paddr_i == `MLW_OFF_CTRL && pwdata_i[`MLW_CTRL_GO] |=> exec ##1 !exec && st_r.irq_stat[`MLW_IRQ_DONE])
    else $error("go did not run exactly one operation");

  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    irq_o == |(st_r.irq_stat & st_r.irq_en))
    else $error("interrupt does not follow enabled status");

  // bus answer, register access, interrupt status and flag checks
  a_ready_high: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pready_o)
    else $error("ready dropped");

  a_unmapped_err: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_setup && !mapped(paddr_i) |=> pslverr_o)
    else $error("unmapped address without error");

  a_mapped_ok: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_setup && mapped(paddr_i) |=> !pslverr_o)
    else $error("mapped address answered with error");

  a_err_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !psel_i |=> !pslverr_o)
    else $error("error left standing while idle");

  a_prdata_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    psel_i && penable_i |=> $stable(prdata_o))
    else $error("read data moved in access phase");

  a_read_dest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_setup && paddr_i == `MLW_OFF_DEST |=> prdata_o == $past(st_r.dest))
    else $error("destination read data wrong");

  a_dest_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_acc && paddr_i == `MLW_OFF_DEST && !exec |=> st_r.dest == $past(pwdata_i))
    else $error("destination write lost");

  a_ctrl_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_acc && paddr_i == `MLW_OFF_CTRL |=> st_r.fam == $past(pwdata_i[`MLW_CTRL_FAM_HI:`MLW_CTRL_FAM_LO])
      && st_r.rec == $past(pwdata_i[`MLW_CTRL_REC]) && st_r.oe == $past(pwdata_i[`MLW_CTRL_OE]))
    else $error("control fields not latched");

  a_cond_ro: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_acc && paddr_i == `MLW_OFF_COND && !exec |=> $stable(st_r.cond))
    else $error("condition field written by software");

  a_clr_drops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_acc && paddr_i == `MLW_OFF_IRQ_CLR && !exec |=> (st_r.irq_stat & $past(pwdata_i[1:0])) == 2'h0)
    else $error("status clear did not drop bits");

  a_done_event: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec |=> st_r.irq_stat[`MLW_IRQ_DONE])
    else $error("done status not set");

  a_ovf_event: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && ovf |=> st_r.irq_stat[`MLW_IRQ_OVF])
    else $error("overflow status not set");

  a_so_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && st_r.so |=> st_r.so)
    else $error("summary overflow lost by an operation");

  a_ovf_cleared: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && st_r.oe && !ovf |=> !st_r.ovf_flag)
    else $error("overflow flag not cleared without overflow");

endmodule : mlw_top
`default_nettype wire

// File: inc/mlw_consts.svh
// Purpose: offsets, field positions, reset values and clamp values of the low-halfword mac unit
// Assumes: byte addresses on an 8-bit apb address, one aligned 32-bit word per register
// Notes: definitions only
`ifndef MLW_CONSTS_SVH
`define MLW_CONSTS_SVH

// register byte offsets
`define MLW_OFF_CTRL 8'h00
`define MLW_OFF_SRC_A 8'h04
`define MLW_OFF_SRC_B 8'h08
`define MLW_OFF_DEST 8'h0C
`define MLW_OFF_FXEXC 8'h10
`define MLW_OFF_COND 8'h14
`define MLW_OFF_IRQ_STAT 8'h18
`define MLW_OFF_IRQ_EN 8'h1C
`define MLW_OFF_IRQ_CLR 8'h20

// control register fields
`define MLW_CTRL_FAM_LO 0
`define MLW_CTRL_FAM_HI 1
`define MLW_CTRL_REC 2
`define MLW_CTRL_OE 3
`define MLW_CTRL_GO 4
`define MLW_CTRL_BUSY 5

// exception register fields
`define MLW_FXEXC_OVF 0
`define MLW_FXEXC_SO 1

// condition field zero: lt, gt, eq, summary copy
`define MLW_COND_SO 0
`define MLW_COND_EQ 1
`define MLW_COND_GT 2
`define MLW_COND_LT 3

// interrupt status, enable and clear layout
`define MLW_IRQ_DONE 0
`define MLW_IRQ_OVF 1

// reset values
`define MLW_RST_WORD 32'h0000_0000
`define MLW_RST_COND 4'h0
`define MLW_RST_IRQ 2'h0

// saturation bounds
`define MLW_SAT_SMAX 32'h7FFF_FFFF
`define MLW_SAT_SMIN 32'h8000_0000
`define MLW_SAT_UMAX 32'hFFFF_FFFF

`endif

// File: inc/mlw_pkg.sv
// Purpose: types of the low-halfword mac unit
// Assumes: mlw_consts.svh holds all numbers
// Notes: family decode lives here because both design files need it
package mlw_pkg;

  // arithmetic family, as written into the control register
  typedef enum logic [1:0] {
    MLW_FAM_MOD_S = 2'h0,
    MLW_FAM_SAT_S = 2'h1,
    MLW_FAM_SAT_U = 2'h2,
    MLW_FAM_MOD_U = 2'h3
  } mlw_fam_e;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    MLW_ST_IDLE = 2'b01,
    MLW_ST_EXEC = 2'b10
  } mlw_state_e;

  // whole state of the top module
  typedef struct packed {
    mlw_state_e state;
    mlw_fam_e fam;
    logic rec;
    logic oe;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] dest;
    logic ovf_flag;
    logic so;
    logic [3:0] cond;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] prdata;
    logic pslverr;
    logic pready;
    logic irq;
  } mlw_st_s;

  // signed families
  function automatic logic mlw_is_signed(input mlw_fam_e f);
    mlw_is_signed = (f == MLW_FAM_MOD_S) || (f == MLW_FAM_SAT_S);
  endfunction : mlw_is_signed

  // saturating families
  function automatic logic mlw_is_sat(input mlw_fam_e f);
    mlw_is_sat = (f == MLW_FAM_SAT_S) || (f == MLW_FAM_SAT_U);
  endfunction : mlw_is_sat

endpackage : mlw_pkg

// File: sim/mac_low_halfword_to_word_test.sv
// Purpose: self-checking bench of the low-halfword mac unit
// Assumes: zero-wait apb slave, results readable two cycles after go
// Notes: every family and form run against five operand sets
`timescale 1ns/1ns
`default_nettype none
`include "mlw_consts.svh"

module mac_low_halfword_to_word_test;
  import mlw_pkg::*;
  logic clk_sys_i;
  logic rst_n_i;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, ovf_flag, so;
  logic [3:0] cond;
  logic [32:0] exp;
  logic [31:0] va[5], vb[5], vd[5];
  int error_cnt, checks_done, cyc_cnt;

  mlw_core_model u_mlw_core_model (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));
  mlw_top u_mlw_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq));

  // 250 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // hang guard
  always @(posedge clk_sys_i) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // expected {overflow, result} of one accumulate
  function automatic logic [32:0] ref_mac(input logic [1:0] f, input logic [31:0] a, b, d);
    logic sgn, sat, ovf;
    logic [31:0] p, r;
    logic [32:0] s;
    sgn = (f == 2'h0) || (f == 2'h1);
    sat = (f == 2'h1) || (f == 2'h2);
    p = sgn ? {{16{a[15]}}, a[15:0]} * {{16{b[15]}}, b[15:0]} : {16'h0, a[15:0]} * {16'h0, b[15:0]};
    s = sgn ? {p[31], p} + {d[31], d} : {1'b0, p} + {1'b0, d};
    ovf = sgn ? (s[32] != s[31]) : s[32];
    r = (sat && ovf) ? (sgn ? (s[32] ? `MLW_SAT_SMIN : `MLW_SAT_SMAX) : `MLW_SAT_UMAX) : s[31:0];
    return {ovf, r};
  endfunction : ref_mac

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    u_mlw_core_model.xfer(1'b1, addr, data, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] want, input logic want_err);
    u_mlw_core_model.xfer(1'b0, addr, 32'h0000_0000, rd, err);
    chk(rd, want);
    chk({31'h0, err}, {31'h0, want_err});
  endtask : rd_chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    cyc_cnt = 0;
    // positive, negative and unsigned overflow sets, a small mixed-sign one, one summing to zero
    va = '{32'hABCD_8000, 32'h0000_0003, 32'h0000_7FFF, 32'h1234_FFFF, 32'h0000_0002};
    vb = '{32'h1234_8000, 32'h5555_FFFE, 32'hFFFF_8000, 32'h0000_FFFF, 32'h0000_FFFF};
    vd = '{32'h7FFF_FFFF, 32'h0000_0001, 32'h8000_0000, 32'h8000_0000, 32'h0000_0002};
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // reset values over the map, then an unmapped word
    for (int i = 0; i < 9; i++) rd_chk(8'(4 * i), 32'h0000_0000, 1'b0);
    rd_chk(8'h24, 32'h0000_0000, 1'b1);
    wr(8'h24, 32'hFFFF_FFFF);
    wr(`MLW_OFF_COND, 32'h0000_000F);
    rd_chk(`MLW_OFF_COND, 32'h0000_0000, 1'b0);
    wr(`MLW_OFF_IRQ_EN, 32'h0000_0003);
    rd_chk(`MLW_OFF_IRQ_EN, 32'h0000_0003, 1'b0);
    $display("test reset_map done");
    ovf_flag = 1'b0;
    so = 1'b0;
    cond = 4'h0;
    // every family, every form, every operand set
    for (int f = 0; f < 4; f++) begin
      for (int m = 0; m < 4; m++) begin
        for (int v = 0; v < 5; v++) begin
          exp = ref_mac(f[1:0], va[v], vb[v], vd[v]);
          wr(`MLW_OFF_IRQ_CLR, 32'h0000_0003);
          wr(`MLW_OFF_SRC_A, va[v]);
          wr(`MLW_OFF_SRC_B, vb[v]);
          wr(`MLW_OFF_DEST, vd[v]);
          wr(`MLW_OFF_CTRL, {27'h0, 1'b1, m[1], m[0], f[1:0]});
          @(posedge clk_sys_i);
          if (m[1]) begin
            ovf_flag = exp[32];
            so = so | exp[32];
          end
          if (m[0]) cond = {exp[31], !exp[31] && (exp[31:0] != 0), exp[31:0] == 0, so};
          rd_chk(`MLW_OFF_DEST, exp[31:0], 1'b0);
          rd_chk(`MLW_OFF_FXEXC, {30'h0, so, ovf_flag}, 1'b0);
          rd_chk(`MLW_OFF_COND, {28'h0, cond}, 1'b0);
          rd_chk(`MLW_OFF_IRQ_STAT, {30'h0, exp[32], 1'b1}, 1'b0);
          chk({31'h0, irq}, 32'h0000_0001);
        end
      end
    end
    $display("test families_forms done");
    // software clears the sticky summary flag
    wr(`MLW_OFF_FXEXC, 32'h0000_0000);
    rd_chk(`MLW_OFF_FXEXC, 32'h0000_0000, 1'b0);
    // masking drops the line, clearing drops the status
    wr(`MLW_OFF_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`MLW_OFF_IRQ_CLR, 32'h0000_0003);
    rd_chk(`MLW_OFF_IRQ_STAT, 32'h0000_0000, 1'b0);
    rd_chk(`MLW_OFF_IRQ_CLR, 32'h0000_0000, 1'b0);
    $display("test irq_flags done");
    give_verdict();
  end
endmodule : mac_low_halfword_to_word_test

`default_nettype wire

// File: sim/mlw_core_model.sv
// Purpose: core-side model that issues apb transfers to the mac unit
// Assumes: slave answers with pready, sampled at rising edges
// Notes: idle cycle between transfers; request held until pready seen
`timescale 1ns/1ns
`default_nettype none

module mlw_core_model (
  input wire logic clk_sys_i, // core clock
  output logic psel_o, // apb select
  output logic penable_o, // apb access phase
  output logic pwrite_o, // apb direction
  output logic [7:0] paddr_o, // apb byte address
  output logic [31:0] pwdata_o, // apb write data
  input wire logic [31:0] prdata_i, // apb read data
  input wire logic pready_i, // apb ready
  input wire logic pslverr_i // apb error
);
  // bus idle at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // one apb transfer: setup, access until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk_sys_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= addr;
    pwdata_o <= wdata;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    do @(posedge clk_sys_i); while (pready_i !== 1'b1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~wdata; // stale data not left on the bus
  endtask : xfer
endmodule : mlw_core_model

`default_nettype wire
